/* File: verilog/ldeq_pkg.sv */
package ldeq_pkg;
  // ***********************************
  // register offsets (printed offsets are not all multiples of four: index, byte = 4*index)
  // ***********************************
  localparam logic [7:0] IDX_LANE2_DRIVE = 8'h34;
  localparam logic [7:0] IDX_RSVD_A = 8'h35;
  localparam logic [7:0] IDX_RSVD_B = 8'h4D;
  localparam logic [7:0] IDX_EQ_L1_L2 = 8'h4E;
  localparam logic [7:0] IDX_EQ_CLK_L0 = 8'h4F;
  // mode inputs captured from the global control register, own offset
  localparam logic [7:0] IDX_MODE_STATUS = 8'h50;
  localparam logic [9:0] BYTE_SHIFT = 10'h002;

  // ***********************************
  // field positions and reset values
  // ***********************************
  localparam int SWING_LSB = 5;
  localparam int SWING_W = 3;
  localparam int PREEMP_LSB = 3;
  localparam int PREEMP_W = 2;
  localparam int EQ_HI_LSB = 4;
  localparam int EQ_LO_LSB = 0;
  localparam int EQ_W = 4;
  localparam logic [7:0] RESET_LANE2_DRIVE = 8'h00;
  localparam logic [7:0] RESET_EQ = 8'h00;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [1:0] PREEMP_NONE = 2'h0;
  localparam logic [1:0] PREEMP_RESERVED = 2'h3;
  localparam logic [2:0] SWING_NOMINAL = 3'h0;
  localparam logic [3:0] EQ_ZERO_DB = 4'h0;

  // ***********************************
  // decoded register selection
  // ***********************************
  typedef enum {
    LDEQ_SEL_DRIVE,
    LDEQ_SEL_RSVD,
    LDEQ_SEL_EQ_HI,
    LDEQ_SEL_EQ_LO,
    LDEQ_SEL_MODE,
    LDEQ_SEL_NONE
  } ldeq_sel_t;
endpackage

/* File: verilog/ldeq_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser for the asynchronous mode levels
module ldeq_sync (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // data
  input wire logic [2:0] d,
  output logic [2:0] q
);
  logic [2:0] meta;

  // first stage read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 3'h0;
      q <= 3'h0;
    end else if (clk_en) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // ldeq_sync

/* File: verilog/ldeq_apply.sv */
`timescale 1ns/100ps
// gates the stored settings into the analog-facing values
module ldeq_apply (
  // mode levels
  input wire logic alt_port_mode,
  input wire logic lane_select,
  // stored settings
  input wire logic [2:0] swing_in,
  input wire logic [1:0] preemp_in,
  // applied settings, valid flag
  output logic [2:0] swing_out,
  output logic [1:0] preemp_out,
  output logic use_per_lane
);
  always_comb begin
    use_per_lane = alt_port_mode & lane_select; // see R03 see R06
    swing_out = use_per_lane ? swing_in : ldeq_pkg::SWING_NOMINAL;
    // reserved code is never driven to the lane, too risky for the driver
    if (!use_per_lane || preemp_in == ldeq_pkg::PREEMP_RESERVED) begin
      preemp_out = ldeq_pkg::PREEMP_NONE; // see R02
    end else begin
      preemp_out = preemp_in;
    end
  end
endmodule // ldeq_apply

/* File: verilog/ldeq_bank.sv */
`timescale 1ns/100ps
// How it works
// R01 - swing field bits 7:5, resets nominal
// R02 - pre-emphasis bits 4:3, code 11 reserved
// R03 - per-lane fields need individual-lane select bit
// R04 - video output mode ignores pre-emphasis writes
// R05 - clock lane never gets pre-emphasis
// R06 - settings apply only in alternate-port mode
// R07 - two reserved registers read zero
// R08 - eq register: lane1 high, lane2 low
// R09 - eq register: clock high, lane0 low
// R10 - eq codes reset to 0 dB
// R11 - drive register sits at index 34h
// R12 - reserved register writes have no effect
module ldeq_bank (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode levels from the global control register, asynchronous here
  input wire logic alternate_port_mode,
  input wire logic lane_select,
  input wire logic video_mode_swap,
  // applied lane-2 drive settings
  output logic [2:0] lane2_output_swing,
  output logic [1:0] lane2_preemphasis,
  output logic clock_lane_preemphasis,
  // receive equalizer codes
  output logic [3:0] eq_clock_lane,
  output logic [3:0] eq_lane0,
  output logic [3:0] eq_lane1,
  output logic [3:0] eq_lane2,
  output logic settings_valid
);

  // ***********************************
  // declarations
  // ***********************************
  logic [2:0] mode_sync;
  logic alt_mode;
  logic lane_sel;
  logic vid_mode;
  logic [7:0] lane2_drive_control;
  logic [7:0] eq_lane1_lane2;
  logic [7:0] eq_clock_lane0;
  logic [2:0] app_swing;
  logic [1:0] app_preemp;
  logic app_valid;
  logic access;
  logic wr_en;
  logic rd_en;
  ldeq_pkg::ldeq_sel_t sel;
  logic [7:0] rd_byte;

  // ***********************************
  // decode helpers
  // ***********************************
  // byte address to register selection; misaligned or unknown gives none
  function automatic ldeq_pkg::ldeq_sel_t decode(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    decode = ldeq_pkg::LDEQ_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx == {2'h0, ldeq_pkg::IDX_LANE2_DRIVE}) begin
        decode = ldeq_pkg::LDEQ_SEL_DRIVE; // see R11
      end else if (idx == {2'h0, ldeq_pkg::IDX_RSVD_A} || idx == {2'h0, ldeq_pkg::IDX_RSVD_B}) begin
        decode = ldeq_pkg::LDEQ_SEL_RSVD;
      end else if (idx == {2'h0, ldeq_pkg::IDX_EQ_L1_L2}) begin
        decode = ldeq_pkg::LDEQ_SEL_EQ_HI;
      end else if (idx == {2'h0, ldeq_pkg::IDX_EQ_CLK_L0}) begin
        decode = ldeq_pkg::LDEQ_SEL_EQ_LO;
      end else if (idx == {2'h0, ldeq_pkg::IDX_MODE_STATUS}) begin
        decode = ldeq_pkg::LDEQ_SEL_MODE;
      end
    end
  endfunction

  // byte-lane merge of an 8-bit register from lane 0 of the bus
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] strb);
    merge = strb[0] ? wd[7:0] : old;
  endfunction

  // ***********************************
  // mode synchronisation and gating
  // ***********************************
  ldeq_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .d({video_mode_swap, lane_select, alternate_port_mode}),
    .q(mode_sync)
  );
  assign alt_mode = mode_sync[0];
  assign lane_sel = mode_sync[1];
  assign vid_mode = mode_sync[2];

  ldeq_apply u_apply (
    .alt_port_mode(alt_mode),
    .lane_select(lane_sel),
    .swing_in(lane2_drive_control[ldeq_pkg::SWING_LSB +: ldeq_pkg::SWING_W]),
    .preemp_in(lane2_drive_control[ldeq_pkg::PREEMP_LSB +: ldeq_pkg::PREEMP_W]),
    .swing_out(app_swing),
    .preemp_out(app_preemp),
    .use_per_lane(app_valid)
  );

  // ***********************************
  // apb access decode
  // ***********************************
  // zero-wait slave: access phase always completes in its first cycle
  assign access = psel & penable & clk_en;
  assign wr_en = access & pwrite;
  assign rd_en = access & ~pwrite;
  assign sel = decode(paddr);

  // ***********************************
  // register storage
  // ***********************************
  // drive register; pre-emphasis write blocked in video mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane2_drive_control <= ldeq_pkg::RESET_LANE2_DRIVE; // see R01 see R02
    end else if (wr_en && sel == ldeq_pkg::LDEQ_SEL_DRIVE && pstrb[0]) begin
      lane2_drive_control[7:5] <= pwdata[7:5]; // see R01
      lane2_drive_control[2:0] <= pwdata[2:0];
      if (!vid_mode) begin
        lane2_drive_control[4:3] <= pwdata[4:3]; // see R04
      end
    end
  end

  // equalizer codes, lane 1 high nibble, lane 2 low nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_lane1_lane2 <= ldeq_pkg::RESET_EQ; // see R10
    end else if (wr_en && sel == ldeq_pkg::LDEQ_SEL_EQ_HI) begin
      eq_lane1_lane2 <= merge(eq_lane1_lane2, pwdata, pstrb); // see R08
    end
  end

  // equalizer codes, clock high nibble, lane 0 low nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_clock_lane0 <= ldeq_pkg::RESET_EQ; // see R10
    end else if (wr_en && sel == ldeq_pkg::LDEQ_SEL_EQ_LO) begin
      eq_clock_lane0 <= merge(eq_clock_lane0, pwdata, pstrb); // see R09
    end
  end

  // ***********************************
  // read mux
  // ***********************************
  // reserved registers hold no storage, so writes cannot stick
  always_comb begin
    unique case (sel)
      ldeq_pkg::LDEQ_SEL_DRIVE: rd_byte = lane2_drive_control;
      ldeq_pkg::LDEQ_SEL_RSVD: rd_byte = ldeq_pkg::RESERVED_VALUE; // see R07 see R12
      ldeq_pkg::LDEQ_SEL_EQ_HI: rd_byte = eq_lane1_lane2;
      ldeq_pkg::LDEQ_SEL_EQ_LO: rd_byte = eq_clock_lane0;
      ldeq_pkg::LDEQ_SEL_MODE: rd_byte = {4'h0, app_valid, vid_mode, lane_sel, alt_mode};
      ldeq_pkg::LDEQ_SEL_NONE: rd_byte = 8'h00;
    endcase
  end

  // ***********************************
  // bus response
  // ***********************************
  // pready registered high only for the access cycle; errors on unmapped or read-only writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ((sel == ldeq_pkg::LDEQ_SEL_NONE) |
                 (pwrite & (sel == ldeq_pkg::LDEQ_SEL_MODE)));
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ***********************************
  // applied outputs
  // ***********************************
  // clock lane output has no pre-emphasis path at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane2_output_swing <= ldeq_pkg::SWING_NOMINAL;
      lane2_preemphasis <= ldeq_pkg::PREEMP_NONE;
      clock_lane_preemphasis <= 1'b0;
      settings_valid <= 1'b0;
      eq_clock_lane <= ldeq_pkg::EQ_ZERO_DB;
      eq_lane0 <= ldeq_pkg::EQ_ZERO_DB;
      eq_lane1 <= ldeq_pkg::EQ_ZERO_DB;
      eq_lane2 <= ldeq_pkg::EQ_ZERO_DB;
    end else if (clk_en) begin
      lane2_output_swing <= app_swing; // see R03
      lane2_preemphasis <= app_preemp; // see R06
      clock_lane_preemphasis <= 1'b0; // see R05
      settings_valid <= app_valid;
      // equalizer codes only reach the lanes in alternate-port mode
      eq_clock_lane <= alt_mode ? eq_clock_lane0[ldeq_pkg::EQ_HI_LSB +: ldeq_pkg::EQ_W] : ldeq_pkg::EQ_ZERO_DB;
      eq_lane0 <= alt_mode ? eq_clock_lane0[ldeq_pkg::EQ_LO_LSB +: ldeq_pkg::EQ_W] : ldeq_pkg::EQ_ZERO_DB;
      eq_lane1 <= alt_mode ? eq_lane1_lane2[ldeq_pkg::EQ_HI_LSB +: ldeq_pkg::EQ_W] : ldeq_pkg::EQ_ZERO_DB;
      eq_lane2 <= alt_mode ? eq_lane1_lane2[ldeq_pkg::EQ_LO_LSB +: ldeq_pkg::EQ_W] : ldeq_pkg::EQ_ZERO_DB;
    end
  end

  // rd_en kept for symmetry of decode; reads have no side effect
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule // ldeq_bank

/* File: verif/ldeq_bank_monitor.sv */
`timescale 1ns/100ps
// ****
// port checker for the register bank
// ****
module ldeq_bank_monitor (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // applied settings
  input wire logic [2:0] lane2_output_swing,
  input wire logic [1:0] lane2_preemphasis,
  input wire logic clock_lane_preemphasis,
  input wire logic [3:0] eq_clock_lane,
  input wire logic [3:0] eq_lane0,
  input wire logic [3:0] eq_lane1,
  input wire logic [3:0] eq_lane2,
  input wire logic settings_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] wd_q;
  logic [31:0] wd_qq;
  // write data two cycles back, lines up with the applied outputs
  always_ff @(posedge pclk) begin
    wd_q <= pwdata;
    wd_qq <= wd_q;
  end
  // an accepted write, then two cycles with settings in force
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && clk_en && pstrb[0] && paddr == a;
  endsequence
  sequence s_live;
    settings_valid [*2];
  endsequence
  a_drive_applied: assert property (s_wr(12'h0D0) ##1 s_live |-> lane2_output_swing == wd_qq[7:5])
    else $error("swing not applied");
  a_eq_data_lanes: assert property (s_wr(12'h138) ##1 s_live |-> {eq_lane1, eq_lane2} == wd_qq[7:0])
    else $error("lane 1/2 eq not applied");
  a_eq_clock_lane: assert property (s_wr(12'h13C) ##1 s_live |-> {eq_clock_lane, eq_lane0} == wd_qq[7:0])
    else $error("clock/lane 0 eq not applied");
  a_lane_gated: assert property (!settings_valid |-> lane2_output_swing == 3'h0 && lane2_preemphasis == 2'h0)
    else $error("drive applied without lane select");
  a_preemp_legal: assert property (lane2_preemphasis != 2'h3)
    else $error("reserved pre-emphasis driven");
  a_clock_no_preemp: assert property (clock_lane_preemphasis == 1'b0)
    else $error("clock lane pre-emphasis");
  a_rsvd_reads_zero: assert property (psel && penable && pready && !pwrite && (paddr == 12'h0D4 || paddr == 12'h134)
    |-> prdata == 32'h0 && !pslverr)
    else $error("reserved register not zero");
  a_pready_single: assert property (psel && penable && clk_en |-> pready ##1 !pready)
    else $error("pready not one access cycle");
  a_unmapped_err: assert property (psel && penable && pready && (paddr == 12'h0D8 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
endmodule // ldeq_bank_monitor

bind ldeq_bank ldeq_bank_monitor ldeq_bank_monitor_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .lane2_output_swing, .lane2_preemphasis, .clock_lane_preemphasis,
  .eq_clock_lane, .eq_lane0, .eq_lane1, .eq_lane2, .settings_valid);

/* File: verif/ldeq_bank_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
// ****
// testbench top
// ****
module ldeq_bank_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic alternate_port_mode = 1'b1;
  logic lane_select = 1'b1;
  logic video_mode_swap = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, clock_lane_preemphasis, settings_valid;
  logic [2:0] lane2_output_swing;
  logic [1:0] lane2_preemphasis;
  logic [3:0] eq_clock_lane, eq_lane0, eq_lane1, eq_lane2;
  logic [11:0] regs [5] = '{12'h0D0, 12'h0D4, 12'h134, 12'h138, 12'h13C};
  int errors = 0;
  int n_compared = 0;
  ldeq_bank ldeq_bank_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .alternate_port_mode, .lane_select, .video_mode_swap, .lane2_output_swing,
    .lane2_preemphasis, .clock_lane_preemphasis, .eq_clock_lane, .eq_lane0, .eq_lane1, .eq_lane2, .settings_valid);
  always #10 pclk = ~pclk;
  // one transfer, held until pready is seen high; entered just after an edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic er);
    xfer(a, 1'b0, 8'h00);
    `CHK("rdata", {24'h0, e}, rdat)
    `CHK("pslverr", er, rerr)
  endtask
  // mode pins are asynchronous: allow sync plus output register
  task automatic mode(input logic [2:0] m);
    {alternate_port_mode, lane_select, video_mode_swap} <= m;
    repeat (4) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the 130 or so cycles needed
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rd(regs[i], 8'h00, 1'b0);
    // every swing code; pre-emphasis 0..3, reserved 3 held back from the pins
    for (int i = 0; i < 8; i++) begin
      xfer(12'h0D0, 1'b1, {i[2:0], i[1:0], 3'b101});
      rd(12'h0D0, {i[2:0], i[1:0], 3'b101}, 1'b0);
      `CHK("swing", i[2:0], lane2_output_swing)
      `CHK("preemp", (i[1:0] == 2'h3) ? 2'h0 : i[1:0], lane2_preemphasis)
      `CHK("clkpre", 1'b0, clock_lane_preemphasis)
    end
    // video mode: pre-emphasis write dropped, swing still lands
    mode(3'b111);
    xfer(12'h0D0, 1'b1, 8'h50);
    rd(12'h0D0, 8'h58, 1'b0);
    mode(3'b110);
    xfer(12'h138, 1'b1, 8'hA5);
    xfer(12'h13C, 1'b1, 8'h3C);
    // last write reaches the lane outputs one edge after the transfer ends
    @(posedge pclk);
    `CHK("eq", 16'hA53C, {eq_lane1, eq_lane2, eq_clock_lane, eq_lane0})
    // lane select off drops per-lane drive only
    mode(3'b100);
    `CHK("lanesel", 8'h05, {settings_valid, lane2_output_swing, eq_lane2})
    rd(12'h140, 8'h01, 1'b0);
    mode(3'b000);
    `CHK("altoff", 4'h0, eq_lane1)
    rd(12'h13C, 8'h3C, 1'b0);
    xfer(12'h0D4, 1'b1, 8'hFF);
    xfer(12'h134, 1'b1, 8'hFF);
    rd(12'h0D4, 8'h00, 1'b0);
    rd(12'h134, 8'h00, 1'b0);
    rd(12'h0D8, 8'h00, 1'b1);
    rd(12'h0D1, 8'h00, 1'b1);
    pstrb <= 4'hE;
    xfer(12'h138, 1'b1, 8'h00);
    pstrb <= 4'hF;
    rd(12'h138, 8'hA5, 1'b0);
    end_of_test;
  end
endmodule // ldeq_bank_tb_top
